// [verilog/bsa_ctrl.sv]
// Frame, configuration and power control of the two-channel SAR converter
`timescale 1ns/1ps
`default_nettype none
module bsa_ctrl
   import bsa_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic comp_pin,
   input wire logic cfg_write,
   input wire bsa_pkg::bsa_range_t cfg_range0,
   input wire bsa_pkg::bsa_range_t cfg_range1,
   input wire bsa_pkg::bsa_mode_t cfg_mode,
   input wire logic cfg_ref_int,
   input wire logic cfg_coding_bin,
   input wire bsa_pkg::bsa_pd_t cfg_pd,
   input wire logic cfg_seq_en,
   input wire logic cfg_chan,
   output logic track,
   output logic [bsa_pkg::BSA_RES_BITS-1:0] trial_code,
   output logic dout,
   output logic dout_oe,
   output logic [bsa_pkg::BSA_RES_BITS-1:0] result,
   output logic result_chan,
   output logic result_valid,
   output logic conv_chan,
   output bsa_pkg::bsa_range_t act_range,
   output bsa_pkg::bsa_mode_t act_mode,
   output logic act_coding_bin,
   output logic ref_internal,
   output logic pwr_down,
   output logic standby,
   output logic frame_busy
);
   import bsa_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic cs_n_s;
   logic sclk_s;
   logic comp_s;

   bsa_pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_cs (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin(cs_n_pin),
      .level(cs_n_s)
   );

   bsa_pin_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_sclk (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin(sclk_pin),
      .level(sclk_s)
   );

   bsa_pin_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_comp (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin(comp_pin),
      .level(comp_s)
   );

   logic cs_n_d;
   logic sclk_d;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         cs_n_d <= 1'b1;
         sclk_d <= 1'b0;
      end
      else
      begin
         cs_n_d <= cs_n_s;
         sclk_d <= sclk_s;
      end
   end

   assign cs_fall = cs_n_d && !cs_n_s;
   assign cs_rise = !cs_n_d && cs_n_s;
   assign sclk_rise = !sclk_d && sclk_s && !cs_n_s;

   // ==========================================================
   // Configuration held between host writes
   bsa_range_t range0;
   bsa_range_t range1;
   bsa_mode_t mode;
   logic coding_bin;
   bsa_pd_t pd;
   logic seq_en;
   logic chan_sel;
   bsa_range_t next_range0;
   bsa_range_t next_range1;
   bsa_mode_t next_mode;
   logic next_ref_internal;
   logic next_coding_bin;
   bsa_pd_t next_pd;
   logic next_seq_en;
   logic next_chan_sel;

   always_comb
   begin
      next_range0 = range0;
      next_range1 = range1;
      next_mode = mode;
      next_ref_internal = ref_internal;
      next_coding_bin = coding_bin;
      next_pd = pd;
      next_seq_en = seq_en;
      next_chan_sel = chan_sel;
      if (cfg_write)
      begin
         next_range0 = cfg_range0;
         next_range1 = cfg_range1;
         // Reserved code falls back to the single-ended pair
         next_mode = (cfg_mode == BSA_MODE_RSVD) ? BSA_MODE_SINGLE : cfg_mode;
         next_ref_internal = cfg_ref_int;
         next_coding_bin = cfg_coding_bin;
         next_pd = cfg_pd;
         next_seq_en = cfg_seq_en;
         next_chan_sel = cfg_chan;
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         range0 <= BSA_RANGE_RESET;
         range1 <= BSA_RANGE_RESET;
         mode <= BSA_MODE_RESET;
         ref_internal <= BSA_REF_INT_RESET;
         coding_bin <= BSA_CODING_BIN_RESET;
         pd <= BSA_PD_RESET;
         seq_en <= 1'b0;
         chan_sel <= 1'b0;
      end
      else
      begin
         range0 <= next_range0;
         range1 <= next_range1;
         mode <= next_mode;
         ref_internal <= next_ref_internal;
         coding_bin <= next_coding_bin;
         pd <= next_pd;
         seq_en <= next_seq_en;
         chan_sel <= next_chan_sel;
      end
   end

   // ==========================================================
   // Frame sequencing
   bsa_state_t state;
   bsa_state_t next_state;
   logic [3:0] edge_cnt;
   logic [3:0] next_edge_cnt;
   logic seq_chan;
   logic next_seq_chan;
   logic next_track;
   logic next_conv_chan;
   bsa_range_t next_act_range;
   bsa_mode_t next_act_mode;
   logic next_act_coding_bin;
   logic next_dout_oe;
   logic next_frame_busy;
   logic next_pwr_down;
   logic next_standby;
   logic frame_start;
   logic sar_step;
   logic pick_chan;

   // Full shutdown ignores frames; the core is not powered
   assign frame_start = cs_fall && (pd != BSA_PD_FULL);
   assign sar_step = (state == BSA_ST_CONVERT) && sclk_rise
      && (edge_cnt >= (BSA_EDGE_FIRST_STEP - 4'h1));

   // Differential pairs always convert the pair on channel 0
   always_comb
   begin
      pick_chan = seq_en ? seq_chan : chan_sel;
      if (mode != BSA_MODE_SINGLE)
      begin
         pick_chan = 1'b0;
      end
   end

   always_comb
   begin
      next_state = state;
      next_edge_cnt = edge_cnt;
      next_seq_chan = seq_chan;
      next_track = track;
      next_conv_chan = conv_chan;
      next_act_range = act_range;
      next_act_mode = act_mode;
      next_act_coding_bin = act_coding_bin;
      unique case (state)
         BSA_ST_TRACK:
         begin
            if (frame_start)
            begin
               next_state = BSA_ST_CONVERT;
               next_edge_cnt = 4'h0;
               next_track = 1'b0;
               // Settings frozen for this frame only
               next_conv_chan = pick_chan;
               next_act_range = pick_chan ? range1 : range0;
               next_act_mode = mode;
               next_act_coding_bin = coding_bin;
               next_seq_chan = seq_en ? ~seq_chan : 1'b0;
            end
         end
         BSA_ST_CONVERT:
         begin
            if (cs_rise)
            begin
               // Aborted frame: no result, back to tracking
               next_state = BSA_ST_TRACK;
               next_track = 1'b1;
            end
            else if (sclk_rise)
            begin
               next_edge_cnt = edge_cnt + 4'h1;
               if ((edge_cnt + 4'h1) == BSA_EDGE_TRACK)
               begin
                  next_track = 1'b1;
                  next_state = BSA_ST_WAIT_CS;
               end
            end
         end
         BSA_ST_WAIT_CS:
         begin
            if (cs_rise)
            begin
               next_state = BSA_ST_TRACK;
            end
         end
         default:
         begin
            next_state = BSA_ST_TRACK;
            next_track = 1'b1;
         end
      endcase
   end

   // Power state shown only while idle between frames
   always_comb
   begin
      next_frame_busy = (next_state == BSA_ST_CONVERT);
      next_dout_oe = !cs_n_s;
      // Full shutdown written mid-frame waits for the frame to finish
      next_pwr_down = (next_state == BSA_ST_TRACK)
         && ((pd == BSA_PD_FULL) || (pd == BSA_PD_AUTO_SHUTDOWN));
      next_standby = (pd == BSA_PD_AUTO_STANDBY) && (next_state == BSA_ST_TRACK);
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         state <= BSA_ST_TRACK;
         edge_cnt <= 4'h0;
         seq_chan <= 1'b0;
         track <= 1'b1;
         conv_chan <= 1'b0;
         act_range <= BSA_RANGE_RESET;
         act_mode <= BSA_MODE_RESET;
         act_coding_bin <= BSA_CODING_BIN_RESET;
         dout_oe <= 1'b0;
         frame_busy <= 1'b0;
         pwr_down <= 1'b0;
         standby <= 1'b0;
      end
      else
      begin
         state <= next_state;
         edge_cnt <= next_edge_cnt;
         seq_chan <= next_seq_chan;
         track <= next_track;
         conv_chan <= next_conv_chan;
         act_range <= next_act_range;
         act_mode <= next_act_mode;
         act_coding_bin <= next_act_coding_bin;
         dout_oe <= next_dout_oe;
         frame_busy <= next_frame_busy;
         pwr_down <= next_pwr_down;
         standby <= next_standby;
      end
   end

   // ==========================================================
   // Successive approximation and result capture
   logic sar_done;
   logic [BSA_RES_BITS-1:0] sar_result;
   logic next_result_valid;
   logic [BSA_RES_BITS-1:0] next_result;
   logic next_result_chan;

   // One decision per clock rise from the second, 13 steps end on the tracking edge
   bsa_sar u_sar (
      .clk_sys(clk_sys),
      .reset(reset),
      .start(frame_start && (state == BSA_ST_TRACK)),
      .step(sar_step),
      .comp(comp_s),
      .coding_bin(act_coding_bin),
      .trial(trial_code),
      .result(sar_result),
      .bit_out(dout),
      .done(sar_done)
   );

   always_comb
   begin
      next_result_valid = sar_done;
      next_result = sar_done ? sar_result : result;
      next_result_chan = sar_done ? conv_chan : result_chan;
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         result_valid <= 1'b0;
         result <= '0;
         result_chan <= 1'b0;
      end
      else
      begin
         result_valid <= next_result_valid;
         result <= next_result;
         result_chan <= next_result_chan;
      end
   end
endmodule : bsa_ctrl
`default_nettype wire

// [verilog/bsa_pkg.sv]
// Shared constants and types for the bipolar SAR converter control block
package bsa_pkg;
   // ==========================================================
   // Converter geometry
   localparam int BSA_RES_BITS = 13;
   localparam int BSA_NUM_CODES = 8192;
   localparam logic [3:0] BSA_MSB_IDX = 4'hc;
   localparam logic [3:0] BSA_EDGE_FIRST_STEP = 4'h2;
   localparam logic [3:0] BSA_EDGE_TRACK = 4'he;
   localparam int BSA_SYNC_STAGES = 3;
   // ==========================================================
   // Configuration encodings
   typedef enum logic [1:0]
   {
      BSA_RANGE_PM10 = 2'b00,
      BSA_RANGE_PM5 = 2'b01,
      BSA_RANGE_PM2P5 = 2'b10,
      BSA_RANGE_UNI10 = 2'b11
   } bsa_range_t;
   typedef enum logic [1:0]
   {
      BSA_MODE_SINGLE = 2'b00,
      BSA_MODE_DIFF = 2'b01,
      BSA_MODE_PSEUDO = 2'b10,
      BSA_MODE_RSVD = 2'b11
   } bsa_mode_t;
   typedef enum logic [1:0]
   {
      BSA_PD_NORMAL = 2'b00,
      BSA_PD_FULL = 2'b01,
      BSA_PD_AUTO_SHUTDOWN = 2'b10,
      BSA_PD_AUTO_STANDBY = 2'b11
   } bsa_pd_t;
   typedef enum logic [1:0]
   {
      BSA_ST_TRACK = 2'b00,
      BSA_ST_CONVERT = 2'b01,
      BSA_ST_WAIT_CS = 2'b10
   } bsa_state_t;
   // ==========================================================
   // Power-up defaults
   localparam bsa_mode_t BSA_MODE_RESET = BSA_MODE_SINGLE;
   localparam bsa_range_t BSA_RANGE_RESET = BSA_RANGE_PM10;
   localparam bsa_pd_t BSA_PD_RESET = BSA_PD_NORMAL;
   localparam logic BSA_REF_INT_RESET = 1'b0;
   localparam logic BSA_CODING_BIN_RESET = 1'b0;
endpackage : bsa_pkg

// [verilog/bsa_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bsa_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_level;

   // Level moves only where the last two stages agree
   always_comb
   begin
      next_level = ((stage2 ~^ stage3) & stage3) | ((stage2 ^ stage3) & level);
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
         level <= RESET_VAL;
      end
      else
      begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= next_level;
      end
   end
endmodule : bsa_pin_sync
`default_nettype wire

// [verilog/bsa_sar.sv]
// Successive-approximation register stepped by serial clock enables
`timescale 1ns/1ps
`default_nettype none
module bsa_sar
   import bsa_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic start,
   input wire logic step,
   input wire logic comp,
   input wire logic coding_bin,
   output logic [BSA_RES_BITS-1:0] trial,
   output logic [BSA_RES_BITS-1:0] result,
   output logic bit_out,
   output logic done
);
   logic [3:0] idx;
   logic busy;
   logic [BSA_RES_BITS-1:0] next_trial;
   logic [BSA_RES_BITS-1:0] next_result;
   logic [3:0] next_idx;
   logic next_busy;
   logic next_bit_out;
   logic next_done;

   // Offset-binary internally; twos complement only flips the sign bit
   function automatic logic [BSA_RES_BITS-1:0] apply_coding(
      input logic [BSA_RES_BITS-1:0] raw,
      input logic bin
   );
      apply_coding = bin ? raw : {~raw[BSA_RES_BITS-1], raw[BSA_RES_BITS-2:0]};
   endfunction : apply_coding

   always_comb
   begin
      next_trial = trial;
      next_result = result;
      next_idx = idx;
      next_busy = busy;
      next_bit_out = bit_out;
      next_done = 1'b0;
      if (start)
      begin
         next_trial = '0;
         next_trial[BSA_MSB_IDX] = 1'b1;
         next_idx = BSA_MSB_IDX;
         next_busy = 1'b1;
      end
      else if (step && busy)
      begin
         next_trial[idx] = comp;
         next_bit_out = ((idx == BSA_MSB_IDX) && !coding_bin) ? ~comp : comp;
         if (idx != 4'h0)
         begin
            next_trial[idx - 4'h1] = 1'b1;
            next_idx = idx - 4'h1;
         end
         else
         begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_result = apply_coding(next_trial, coding_bin);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         trial <= '0;
         result <= '0;
         idx <= 4'h0;
         busy <= 1'b0;
         bit_out <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         trial <= next_trial;
         result <= next_result;
         idx <= next_idx;
         busy <= next_busy;
         bit_out <= next_bit_out;
         done <= next_done;
      end
   end
endmodule : bsa_sar
`default_nettype wire

// [bench/bsa_ctrl_asserts.sv]
// Port-level checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module bsa_ctrl_asserts
   import bsa_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic cs_n_pin,
   input wire logic sclk_pin,
   input wire logic cfg_write,
   input wire logic cfg_ref_int,
   input wire logic track,
   input wire logic [bsa_pkg::BSA_RES_BITS-1:0] result,
   input wire logic result_valid,
   input wire logic conv_chan,
   input wire bsa_pkg::bsa_range_t act_range,
   input wire bsa_pkg::bsa_mode_t act_mode,
   input wire logic act_coding_bin,
   input wire logic ref_internal,
   input wire logic pwr_down,
   input wire logic standby,
   input wire logic frame_busy,
   input wire logic dout_oe
);
   // ==========
   // Raw clock rises since select fell; saturates so it never wraps
   logic sclk_q;
   logic [4:0] nrise;
   logic [4:0] next_nrise;
   always_comb
   begin
      next_nrise = nrise;
      if (cs_n_pin)
         next_nrise = 5'h0;
      else if (sclk_pin && !sclk_q && nrise != 5'h1f)
         next_nrise = nrise + 5'h1;
   end
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         sclk_q <= 1'b1;
         nrise <= 5'h0;
      end
      else
      begin
         sclk_q <= sclk_pin;
         nrise <= next_nrise;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ==========
   // Properties
   chk_track_return: assert property ($rose(track) && !cs_n_pin |-> nrise == 5'he)
      else $error("track returned away from the fourteenth clock rise");
   chk_track_hold: assert property (!cs_n_pin && !pwr_down && nrise != 5'h0 && nrise < 5'he
      |-> !track)
      else $error("track high inside a running frame");
   chk_frame_start: assert property ($rose(frame_busy) |-> dout_oe && $fell(track))
      else $error("frame start without hold and output enable");
   chk_valid_pulse: assert property (result_valid |-> $past(frame_busy, 2) && !$past(frame_busy)
      ##1 !result_valid)
      else $error("result pulse out of place");
   chk_result_hold: assert property (!result_valid |-> $stable(result))
      else $error("result changed without a valid pulse");
   chk_ref_follow: assert property (cfg_write |=> ref_internal == $past(cfg_ref_int))
      else $error("reference select did not follow the write");
   chk_settings_frozen: assert property (frame_busy && $past(frame_busy) |-> $stable(act_range)
      && $stable(act_mode) && $stable(act_coding_bin) && $stable(conv_chan))
      else $error("settings changed inside a frame");
   chk_mode_legal: assert property (act_mode != BSA_MODE_RSVD)
      else $error("reserved input mode in use");
   chk_diff_chan: assert property (act_mode == BSA_MODE_DIFF || act_mode == BSA_MODE_PSEUDO
      |-> !conv_chan)
      else $error("paired mode on the second channel");
   chk_power_idle: assert property (pwr_down || standby |-> !frame_busy
      && !(pwr_down && standby))
      else $error("power saving during a conversion");
endmodule : bsa_ctrl_asserts
bind bsa_ctrl bsa_ctrl_asserts bsa_ctrl_asserts_i (.clk_sys, .reset, .cs_n_pin, .sclk_pin,
   .cfg_write, .cfg_ref_int, .track, .result, .result_valid, .conv_chan, .act_range,
   .act_mode, .act_coding_bin, .ref_internal, .pwr_down, .standby, .frame_busy, .dout_oe);
`default_nettype wire

// [bench/bsa_host_model.sv]
// Host and comparator model driving the serial frame pins
`timescale 1ns/1ps
`default_nettype none
module bsa_host_model
   import bsa_pkg::*;
#(
   parameter int HALF = 8,
   parameter int PERIOD = 500
)
(
   input wire logic clk_sys,
   input wire logic [bsa_pkg::BSA_RES_BITS-1:0] trial_code,
   input wire logic [bsa_pkg::BSA_RES_BITS-1:0] vin,
   output logic cs_n_pin,
   output logic sclk_pin,
   output logic comp_pin
);
   // Ideal comparator on the held input, offset binary
   assign comp_pin = (vin >= trial_code);
   initial
   begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b1;
   end
   // ==========
   // One frame of n clock rises; clock idles high between frames
   task automatic frame(input int n);
      int t;
      t = (2 * n + 1) * HALF + 81;
      @(posedge clk_sys);
      #1 cs_n_pin = 1'b0;
      for (int k = 0; k < 2 * n; k++)
      begin
         repeat (HALF) @(posedge clk_sys);
         #1 sclk_pin = ~sclk_pin;
      end
      repeat (HALF) @(posedge clk_sys);
      #1 cs_n_pin = 1'b1;
      // 80 cycles is 320 ns of tracking before the next fall
      repeat (80) @(posedge clk_sys);
      if (t < PERIOD)
         repeat (PERIOD - t) @(posedge clk_sys);
   endtask : frame
endmodule : bsa_host_model
`default_nettype wire

// [bench/bsa_ctrl_tb.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module bsa_ctrl_tb;
   import bsa_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic cfg_write = 1'b0, cfg_ref_int = 1'b0, cfg_coding_bin = 1'b0;
   logic cfg_seq_en = 1'b0, cfg_chan = 1'b0;
   bsa_range_t cfg_range0 = BSA_RANGE_PM10, cfg_range1 = BSA_RANGE_PM10, act_range;
   bsa_mode_t cfg_mode = BSA_MODE_SINGLE, act_mode;
   bsa_pd_t cfg_pd = BSA_PD_NORMAL;
   logic cs_n_pin, sclk_pin, comp_pin, track, dout, dout_oe, result_chan, result_valid;
   logic conv_chan, act_coding_bin, ref_internal, pwr_down, standby, frame_busy;
   logic [12:0] trial_code, result;
   logic [12:0] vin = 13'h0;
   logic [12:0] dsh = 13'h0;
   int n_errors = 0;
   int cmp_count = 0;
   int nv = 0;
   int cycles = 0;
   always #2 clk_sys = ~clk_sys;
   bsa_ctrl bsa_ctrl_i (.clk_sys, .reset, .cs_n_pin, .sclk_pin, .comp_pin, .cfg_write,
      .cfg_range0, .cfg_range1, .cfg_mode, .cfg_ref_int, .cfg_coding_bin, .cfg_pd,
      .cfg_seq_en, .cfg_chan, .track, .trial_code, .dout, .dout_oe, .result, .result_chan,
      .result_valid, .conv_chan, .act_range, .act_mode, .act_coding_bin, .ref_internal,
      .pwr_down, .standby, .frame_busy);
   bsa_host_model bsa_host_model_i (.clk_sys, .trial_code, .vin, .cs_n_pin, .sclk_pin,
      .comp_pin);
   // Host takes dout on each serial clock fall and on select rising
   always @(negedge sclk_pin or posedge cs_n_pin)
   begin
      dsh <= {dsh[11:0], dout};
   end
   // ==========
   // Tasks
   task automatic close_out();
      $display("Mismatches %0d in %0d comparisons", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic check(input logic [12:0] got, input logic [12:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic cfg(input bsa_range_t r0, r1, input bsa_mode_t m, input logic rf, cb,
      input bsa_pd_t pd, input logic sq, ch);
      @(posedge clk_sys);
      #1;
      cfg_range0 = r0;
      cfg_range1 = r1;
      cfg_mode = m;
      cfg_ref_int = rf;
      cfg_coding_bin = cb;
      cfg_pd = pd;
      cfg_seq_en = sq;
      cfg_chan = ch;
      cfg_write = 1'b1;
      @(posedge clk_sys);
      #1 cfg_write = 1'b0;
   endtask : cfg
   task automatic conv(input logic [12:0] v, input int n);
      vin = v;
      nv = 0;
      bsa_host_model_i.frame(n);
   endtask : conv
   // Result pulses and the hang limit; about 13 frames of 500 cycles expected
   always @(posedge clk_sys)
   begin
      cycles++;
      if (result_valid === 1'b1)
         nv++;
      if (cycles == 20000)
      begin
         n_errors++;
         close_out();
      end
   end
   // ==========
   // Scenarios
   initial
   begin
      logic ch;
      logic c0;
      logic [12:0] v;
      repeat (2) @(posedge clk_sys);
      #1 reset = 1'b0;
      @(posedge clk_sys);
      #1;
      check(track, 1'b1);
      check(ref_internal, 1'b0);
      conv(13'h0a5c, 14);
      check(13'(nv), 13'h1);
      check(result, 13'h1a5c);
      check(dsh, 13'h1a5c);
      check(act_mode, BSA_MODE_SINGLE);
      check(act_range, BSA_RANGE_PM10);
      for (int i = 0; i < 4; i++)
      begin
         v = 13'h1000 + 13'(i * 291);
         cfg(bsa_range_t'(i), bsa_range_t'(3 - i), bsa_mode_t'(i), 1'b1, 1'b1,
            BSA_PD_NORMAL, 1'b0, 1'b1);
         check(ref_internal, 1'b1);
         conv(v, 14);
         ch = (i == 1 || i == 2) ? 1'b0 : 1'b1;
         check(result, v);
         check(dsh, v);
         check(result_chan, ch);
         check(act_range, ch ? 13'(3 - i) : 13'(i));
         check(act_mode, (i == 3) ? 13'h0 : 13'(i));
      end
      cfg(BSA_RANGE_PM5, BSA_RANGE_UNI10, BSA_MODE_SINGLE, 1'b0, 1'b1, BSA_PD_NORMAL, 1'b1,
         1'b0);
      conv(13'h0123, 14);
      c0 = conv_chan;
      check(c0, 1'b0);
      check(act_coding_bin, 1'b1);
      conv(13'h1fff, 14);
      check(c0 ^ conv_chan, 1'b1);
      check(conv_chan, 1'b1);
      check(act_range, BSA_RANGE_UNI10);
      check(result, 13'h1fff);
      check(dsh, 13'h1fff);
      // Write lands mid-frame; the frame must keep binary coding
      fork
         conv(13'h0777, 14);
         begin
            repeat (60) @(posedge clk_sys);
            cfg(BSA_RANGE_PM10, BSA_RANGE_PM10, BSA_MODE_SINGLE, 1'b0, 1'b0, BSA_PD_NORMAL,
               1'b0, 1'b0);
         end
      join
      check(result, 13'h0777);
      conv(13'h0777, 14);
      check(result, 13'h1777);
      conv(13'h0abc, 6);
      check(13'(nv), 13'h0);
      check(track, 1'b1);
      for (int p = 2; p < 4; p++)
      begin
         cfg(BSA_RANGE_PM10, BSA_RANGE_PM10, BSA_MODE_SINGLE, 1'b0, 1'b0, bsa_pd_t'(p),
            1'b0, 1'b0);
         conv(13'h0100, 14);
         check(13'(nv), 13'h1);
         check({pwr_down, standby}, (p == 2) ? 13'h2 : 13'h1);
      end
      cfg(BSA_RANGE_PM10, BSA_RANGE_PM10, BSA_MODE_SINGLE, 1'b0, 1'b0, BSA_PD_FULL, 1'b0,
         1'b0);
      conv(13'h0100, 14);
      check(13'(nv), 13'h0);
      check(pwr_down, 1'b1);
      close_out();
   end
endmodule : bsa_ctrl_tb
`default_nettype wire
